/* rtl/pfp_map.vh */
// Register map, field positions, reset values and codes of the pixel fragment pipeline
`ifndef PFP_MAP_VH
`define PFP_MAP_VH

`define PFP_OFF_DEPTH     8'h00
`define PFP_OFF_COMB      8'h04
`define PFP_OFF_PALOFS    8'h08
`define PFP_OFF_PALDAT    8'h0C
`define PFP_OFF_BIAS      8'h10
`define PFP_OFF_CKLO      8'h14
`define PFP_OFF_CKHI      8'h18
`define PFP_OFF_FOGCOL    8'h1C
`define PFP_OFF_FOGTAB    8'h20
`define PFP_OFF_STAT      8'h24

`define PFP_DB_DEPTH_EN   0
`define PFP_DB_WBUF       1
`define PFP_DB_FUNC_LO    2
`define PFP_DB_FUNC_HI    4
`define PFP_DB_DALPHA     5
`define PFP_DB_CKEY       6
`define PFP_DB_CRANGE     7
`define PFP_DB_AA         8
`define PFP_DB_AA_F2B     9

`define PFP_CC_SRCF_LO    0
`define PFP_CC_SRCF_HI    2
`define PFP_CC_DSTF_LO    3
`define PFP_CC_DSTF_HI    5
`define PFP_CC_BLEND      6
`define PFP_CC_FOG        7
`define PFP_CC_DITHER     8

`define PFP_RST_DEPTH     10'h01C
`define PFP_RST_COMB      9'h102

`define PFP_F_ZERO        3'h0
`define PFP_F_SRCA        3'h1
`define PFP_F_ONE         3'h2
`define PFP_F_INV_SRCA    3'h3
`define PFP_F_DSTA        3'h4
`define PFP_F_INV_DSTA    3'h5
`define PFP_F_SAT         3'h6

`define PFP_TF_DIRECT     2'h0
`define PFP_TF_PALETTE    2'h1
`define PFP_TF_COMPRESS   2'h2

`endif

/* rtl/pfp_dither.v */
// Ordered 4x4 dither from 24-bit RGB to 5-6-5
`timescale 1ns/1ns
`default_nettype none

module pfp_dither (
	// Control and position
	input  wire        en,
	input  wire [1:0]  px,
	input  wire [1:0]  py,
	// Colour
	input  wire [23:0] rgb_in,
	output wire [15:0] rgb_out
);

	function [3:0] bayer;
		input [1:0] x;
		input [1:0] y;
		begin
			case ({y, x})
				4'h0: bayer = 4'h0;  4'h1: bayer = 4'h8;  4'h2: bayer = 4'h2;  4'h3: bayer = 4'hA;
				4'h4: bayer = 4'hC;  4'h5: bayer = 4'h4;  4'h6: bayer = 4'hE;  4'h7: bayer = 4'h6;
				4'h8: bayer = 4'h3;  4'h9: bayer = 4'hB;  4'hA: bayer = 4'h1;  4'hB: bayer = 4'h9;
				default: bayer = (y == 2'h3 && x == 2'h0) ? 4'hF : (x == 2'h1) ? 4'h7 : (x == 2'h2) ? 4'hD : 4'h5;
			endcase
		end
	endfunction

	// Saturating add keeps white from wrapping to black
	function [7:0] sat_add;
		input [7:0] c;
		input [2:0] d;
		reg   [8:0] s;
		begin
			s = {1'b0, c} + {6'h00, d};
			sat_add = s[8] ? 8'hFF : s[7:0];
		end
	endfunction

	wire [3:0] thr = en ? bayer(px, py) : 4'h0;
	wire [7:0] r8  = sat_add(rgb_in[23:16], thr[3:1]);
	wire [7:0] g8  = sat_add(rgb_in[15:8], {1'b0, thr[3:2]});
	wire [7:0] b8  = sat_add(rgb_in[7:0], thr[3:1]);

	assign rgb_out = {r8[7:3], g8[7:2], b8[7:3]};

endmodule
`default_nettype wire

/* rtl/pfp_pipe.v */
// Pixel fragment back end: texture decode, depth, chroma, fog, blend, dither, write
// What this block does
// - Holds a 256-entry palette, loaded by host writes or texture-memory fill.
// - Palette offset register shifts the addressed entry for loads and lookups.
// - Expands 8-bit narrow-channel compressed texels back to RGB colour.
// - Finds edge pixels itself and renders them with reduced intensity.
// - Edge blending uses alpha-saturate front-to-back, plain alpha back-to-front.
// - Depth test picks one of eight compare functions.
// - Optional depth from reciprocal-W in a 16-bit float form.
// - A non-negative constant depth bias is added before the compare; a negative one gives 0, or a wrapped sum on underflow.
// - Destination alpha in aux storage only while depth test is off.
// - Result is source times source factor plus destination times destination factor.
// - Blend factors carry eight fraction bits, 1.8 form.
// - Fog indexes a 64-entry table by 6-bit float reciprocal-W.
// - Fog table output weighs fog colour against pixel colour.
// - Low float bits interpolate between adjacent fog entries.
// - Internal 32-bit ARGB, stored colour only 5-6-5.
// - Dithers 24-bit colour to 16-bit before the colour write.
// - Host 24-bit frame-buffer pixels are dithered at full rate.
// - Chroma key match drops the pixel, frame buffer unchanged.
// - Chroma range writes the pixel only when inside the range.
// - Coordinates span -4096 to +4095 on both axes.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "pfp_map.vh"

module pfp_pipe (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_we,
	input  wire        reg_re,
	output reg  [31:0] reg_rdata,
	// Palette fill from texture memory
	input  wire        pal_ld_valid,
	input  wire [7:0]  pal_ld_idx,
	input  wire [23:0] pal_ld_rgb,
	// Fragment in, with old buffer contents
	input  wire        frag_valid,
	output wire        frag_ready,
	input  wire        frag_lfb,
	input  wire [12:0] frag_x,
	input  wire [12:0] frag_y,
	input  wire [31:0] frag_argb,
	input  wire [7:0]  frag_tex,
	input  wire [1:0]  frag_tfmt,
	input  wire [7:0]  frag_cov,
	input  wire [15:0] frag_z,
	input  wire [15:0] frag_w,
	input  wire [15:0] frag_old_rgb,
	input  wire [15:0] frag_old_aux,
	// Frame-buffer write out
	output reg         fb_valid,
	input  wire        fb_ready,
	output reg  [12:0] fb_x,
	output reg  [12:0] fb_y,
	output reg  [15:0] fb_rgb,
	output reg  [15:0] fb_aux,
	output reg         fb_aux_we
);

	// Setup and tables
	reg  [9:0]  depth_and_buffer_setup_r;
	reg  [8:0]  color_combine_setup_r;
	reg  [7:0]  pal_ofs_r;
	reg  [15:0] bias_r;
	reg  [23:0] ck_lo_r;
	reg  [23:0] ck_hi_r;
	reg  [23:0] fog_col_r;
	reg  [15:0] pass_cnt_r;
	reg  [15:0] rej_cnt_r;
	reg  [23:0] pal_mem [0:255];
	reg  [7:0]  fog_mem [0:63];

	wire       depth_en = depth_and_buffer_setup_r[`PFP_DB_DEPTH_EN];
	wire       dalpha   = depth_and_buffer_setup_r[`PFP_DB_DALPHA] & ~depth_en;
	wire [2:0] zfunc    = depth_and_buffer_setup_r[`PFP_DB_FUNC_HI:`PFP_DB_FUNC_LO];
	wire       aa_en    = depth_and_buffer_setup_r[`PFP_DB_AA];
	wire       aa_f2b   = depth_and_buffer_setup_r[`PFP_DB_AA_F2B];

	function [7:0] clamp10;
		input signed [9:0] v;
		begin
			clamp10 = v[9] ? 8'h00 : (v[8] ? 8'hFF : v[7:0]);
		end
	endfunction

	// Leading-zero exponent gives far more range near the eye than linear depth
	function [15:0] wfloat;
		input [15:0] w;
		reg   [4:0]  lz;
		reg   [15:0] sh;
		integer      i;
		begin
			lz = 5'h0F;
			for (i = 0; i < 16; i = i + 1)
				if (w[i])
					lz = 5'h0F - i[4:0];
			sh = w << lz;
			wfloat = (w == 16'h0000) ? 16'hF000 : {lz[3:0], sh[14:3]};
		end
	endfunction

	function zcmp;
		input [2:0]  f;
		input [15:0] a;
		input [15:0] b;
		begin
			case (f)
				3'h0: zcmp = 1'b0;
				3'h1: zcmp = a < b;
				3'h2: zcmp = a == b;
				3'h3: zcmp = a <= b;
				3'h4: zcmp = a > b;
				3'h5: zcmp = a != b;
				3'h6: zcmp = a >= b;
				default: zcmp = 1'b1;
			endcase
		end
	endfunction

	function [8:0] factor;
		input [2:0] sel;
		input [7:0] as;
		input [7:0] ad;
		begin
			case (sel)
				`PFP_F_ZERO:     factor = 9'h000;
				`PFP_F_SRCA:     factor = {1'b0, as};
				`PFP_F_ONE:      factor = 9'h100;
				`PFP_F_INV_SRCA: factor = 9'h100 - {1'b0, as};
				`PFP_F_DSTA:     factor = {1'b0, ad};
				`PFP_F_INV_DSTA: factor = 9'h100 - {1'b0, ad};
				`PFP_F_SAT:      factor = (as < ~ad) ? {1'b0, as} : {1'b0, ~ad};
				default:         factor = 9'h100;
			endcase
		end
	endfunction

	// Weighted sum of two 8-bit values with 1.8 weights, saturated
	function [7:0] mix;
		input [7:0] s;
		input [8:0] fs;
		input [7:0] d;
		input [8:0] fd;
		reg   [17:0] sum;
		begin
			// Products widened first so no bit of either term is lost
			sum = {10'h000, s} * {9'h000, fs} + {10'h000, d} * {9'h000, fd};
			mix = (sum[17:8] > 10'h0FF) ? 8'hFF : sum[15:8];
		end
	endfunction

	// Register port
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			depth_and_buffer_setup_r <= `PFP_RST_DEPTH;
			color_combine_setup_r    <= `PFP_RST_COMB;
			pal_ofs_r                <= 8'h00;
			bias_r                   <= 16'h0000;
			ck_lo_r                  <= 24'h000000;
			ck_hi_r                  <= 24'h000000;
			fog_col_r                <= 24'h000000;
			reg_rdata                <= 32'h00000000;
		end
		else
		begin
			if (reg_we)
			begin
				case (reg_addr)
					`PFP_OFF_DEPTH:  depth_and_buffer_setup_r <= reg_wdata[9:0];
					`PFP_OFF_COMB:   color_combine_setup_r <= reg_wdata[8:0];
					`PFP_OFF_PALOFS: pal_ofs_r <= reg_wdata[7:0];
					`PFP_OFF_BIAS:   bias_r <= reg_wdata[15:0];
					`PFP_OFF_CKLO:   ck_lo_r <= reg_wdata[23:0];
					`PFP_OFF_CKHI:   ck_hi_r <= reg_wdata[23:0];
					`PFP_OFF_FOGCOL: fog_col_r <= reg_wdata[23:0];
					default:         ;
				endcase
			end
			reg_rdata <= 32'h00000000;
			if (reg_re)
			begin
				case (reg_addr)
					`PFP_OFF_DEPTH:  reg_rdata <= {22'h0, depth_and_buffer_setup_r};
					`PFP_OFF_COMB:   reg_rdata <= {23'h0, color_combine_setup_r};
					`PFP_OFF_PALOFS: reg_rdata <= {24'h000000, pal_ofs_r};
					`PFP_OFF_BIAS:   reg_rdata <= {16'h0000, bias_r};
					`PFP_OFF_CKLO:   reg_rdata <= {8'h00, ck_lo_r};
					`PFP_OFF_CKHI:   reg_rdata <= {8'h00, ck_hi_r};
					`PFP_OFF_FOGCOL: reg_rdata <= {8'h00, fog_col_r};
					`PFP_OFF_STAT:   reg_rdata <= {rej_cnt_r, pass_cnt_r};
					default:         reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Tables hold no reset; host must load them before use
	always @(posedge clk)
	begin
		if (reg_we && reg_addr == `PFP_OFF_PALDAT)
			pal_mem[reg_wdata[31:24] + pal_ofs_r] <= reg_wdata[23:0];
		else if (pal_ld_valid)
			pal_mem[pal_ld_idx + pal_ofs_r] <= pal_ld_rgb;
		if (reg_we && reg_addr == `PFP_OFF_FOGTAB)
			fog_mem[reg_wdata[13:8]] <= reg_wdata[7:0];
	end

	// Stage 1: texture decode and depth test
	wire        adv = ~fb_valid | fb_ready;
	assign frag_ready = adv;
	wire        take = frag_valid & adv;

	wire [7:0]  pal_idx = frag_tex + pal_ofs_r;
	wire [23:0] pal_rgb = pal_mem[pal_idx];
	wire [7:0]  ybase   = {frag_tex[7:4], frag_tex[7:4]};
	wire [9:0]  ra      = {2'b00, ybase} + {{3{frag_tex[3]}}, frag_tex[2], 6'h00};
	wire [9:0]  bb      = {2'b00, ybase} + {{3{frag_tex[1]}}, frag_tex[0], 6'h00};
	reg  [23:0] tex_rgb;

	always @*
	begin
		case (frag_tfmt)
			`PFP_TF_PALETTE:  tex_rgb = pal_rgb;
			`PFP_TF_COMPRESS: tex_rgb = {clamp10(ra), ybase, clamp10(bb)};
			default:          tex_rgb = frag_argb[23:0];
		endcase
	end

	wire [15:0] wf     = wfloat(frag_w);
	wire [15:0] zq     = depth_and_buffer_setup_r[`PFP_DB_WBUF] ? wf : frag_z;
	wire [16:0] zsum   = {1'b0, zq} + {{1{bias_r[15]}}, bias_r};
	wire [15:0] zb     = (bias_r[15] & ~zsum[16]) ? 16'h0000 : ((~bias_r[15] & zsum[16]) ? 16'hFFFF : zsum[15:0]);
	wire        zpass  = frag_lfb | ~depth_en | zcmp(zfunc, zb, frag_old_aux);
	wire        edge_p = aa_en & ~frag_lfb & (frag_cov != 8'hFF);
	wire [15:0] acov   = frag_argb[31:24] * frag_cov;

	reg         s1_v;
	reg         s1_lfb;
	reg         s1_edge;
	reg  [12:0] s1_x;
	reg  [12:0] s1_y;
	reg  [31:0] s1_argb;
	reg  [15:0] s1_z;
	reg  [5:0]  s1_fidx;
	reg  [7:0]  s1_ffrac;
	reg  [15:0] s1_old_rgb;
	reg  [7:0]  s1_old_a;

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			s1_v      <= 1'b0;
			pass_cnt_r <= 16'h0000;
			rej_cnt_r <= 16'h0000;
		end
		else if (adv)
		begin
			s1_v <= take & zpass;
			if (take & ~zpass)
				rej_cnt_r <= rej_cnt_r + 16'h0001;
			if (fb_valid & fb_ready)
				pass_cnt_r <= pass_cnt_r + 16'h0001;
		end
		if (adv)
		begin
			s1_lfb     <= frag_lfb;
			s1_edge    <= edge_p;
			s1_x       <= frag_x;
			s1_y       <= frag_y;
			s1_argb    <= {edge_p ? acov[15:8] : frag_argb[31:24], tex_rgb};
			s1_z       <= zb;
			s1_fidx    <= wf[15:10];
			s1_ffrac   <= wf[9:2];
			s1_old_rgb <= frag_old_rgb;
			s1_old_a   <= dalpha ? frag_old_aux[7:0] : 8'hFF;
		end
	end

	// Stage 2: chroma, fog, blend
	wire [7:0] cr = s1_argb[23:16];
	wire [7:0] cg = s1_argb[15:8];
	wire [7:0] cb = s1_argb[7:0];
	wire       in_rng = (cr >= ck_lo_r[23:16]) & (cr <= ck_hi_r[23:16]) & (cg >= ck_lo_r[15:8]) &
	                    (cg <= ck_hi_r[15:8]) & (cb >= ck_lo_r[7:0]) & (cb <= ck_hi_r[7:0]);
	reg        chroma_ok;

	always @*
	begin
		if (s1_lfb)
			chroma_ok = 1'b1;
		else if (depth_and_buffer_setup_r[`PFP_DB_CRANGE])
			chroma_ok = in_rng;
		else if (depth_and_buffer_setup_r[`PFP_DB_CKEY])
			chroma_ok = (s1_argb[23:0] != ck_lo_r);
		else
			chroma_ok = 1'b1;
	end

	wire [7:0]  fog_t0  = fog_mem[s1_fidx];
	wire [7:0]  fog_t1  = (s1_fidx == 6'h3F) ? fog_t0 : fog_mem[s1_fidx + 6'h01];
	wire [7:0]  fog_w   = mix(fog_t0, 9'h100 - {1'b0, s1_ffrac}, fog_t1, {1'b0, s1_ffrac});
	wire        fog_on  = color_combine_setup_r[`PFP_CC_FOG] & ~s1_lfb;
	wire [8:0]  fw      = fog_on ? {1'b0, fog_w} : 9'h000;
	wire [23:0] fogged  = {mix(cr, 9'h100 - fw, fog_col_r[23:16], fw),
	                       mix(cg, 9'h100 - fw, fog_col_r[15:8], fw),
	                       mix(cb, 9'h100 - fw, fog_col_r[7:0], fw)};

	wire [7:0]  dr = {s1_old_rgb[15:11], s1_old_rgb[15:13]};
	wire [7:0]  dg = {s1_old_rgb[10:5], s1_old_rgb[10:9]};
	wire [7:0]  db = {s1_old_rgb[4:0], s1_old_rgb[4:2]};
	wire [7:0]  sa = s1_argb[31:24];
	reg  [2:0]  fsel_s;
	reg  [2:0]  fsel_d;

	always @*
	begin
		if (s1_edge)
		begin
			fsel_s = aa_f2b ? `PFP_F_SAT : `PFP_F_SRCA;
			fsel_d = aa_f2b ? `PFP_F_ONE : `PFP_F_INV_SRCA;
		end
		else if (color_combine_setup_r[`PFP_CC_BLEND] & ~s1_lfb)
		begin
			fsel_s = color_combine_setup_r[`PFP_CC_SRCF_HI:`PFP_CC_SRCF_LO];
			fsel_d = color_combine_setup_r[`PFP_CC_DSTF_HI:`PFP_CC_DSTF_LO];
		end
		else
		begin
			fsel_s = `PFP_F_ONE;
			fsel_d = `PFP_F_ZERO;
		end
	end

	wire [8:0]  fs = factor(fsel_s, sa, s1_old_a);
	wire [8:0]  fd = factor(fsel_d, sa, s1_old_a);
	wire [31:0] blended = {mix(sa, fs, s1_old_a, fd),
	                       mix(fogged[23:16], fs, dr, fd),
	                       mix(fogged[15:8], fs, dg, fd),
	                       mix(fogged[7:0], fs, db, fd)};

	reg         s2_v;
	reg  [12:0] s2_x;
	reg  [12:0] s2_y;
	reg  [23:0] s2_rgb;
	reg  [15:0] s2_aux;
	reg         s2_aux_we;

	always @(posedge clk)
	begin
		if (!rst_n)
			s2_v <= 1'b0;
		else if (adv)
			s2_v <= s1_v & chroma_ok;
		if (adv)
		begin
			s2_x      <= s1_x;
			s2_y      <= s1_y;
			s2_rgb    <= blended[23:0];
			s2_aux    <= depth_en ? s1_z : {8'h00, blended[31:24]};
			s2_aux_we <= ~s1_lfb & (depth_en | dalpha);
		end
	end

	// Stage 3: dither and frame-buffer write
	wire [15:0] rgb565;

	pfp_dither u_dither (
		.en      (color_combine_setup_r[`PFP_CC_DITHER]),
		.px      (s2_x[1:0]),
		.py      (s2_y[1:0]),
		.rgb_in  (s2_rgb),
		.rgb_out (rgb565)
	);

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			fb_valid  <= 1'b0;
			fb_x      <= 13'h0000;
			fb_y      <= 13'h0000;
			fb_rgb    <= 16'h0000;
			fb_aux    <= 16'h0000;
			fb_aux_we <= 1'b0;
		end
		else if (adv)
		begin
			fb_valid  <= s2_v;
			fb_x      <= s2_x;
			fb_y      <= s2_y;
			fb_rgb    <= rgb565;
			fb_aux    <= s2_aux;
			fb_aux_we <= s2_aux_we;
		end
	end

endmodule
`default_nettype wire

/* verification/pfp_fb_mem.sv */
// Frame-buffer memory stand-in that takes colour writes with random stalls
`timescale 1ns/1ns
`default_nettype none

module pfp_fb_mem (
	// Clock and mode
	input  wire logic clk,
	input  wire logic slow,
	// Write handshake
	output var  logic fb_ready
);
	integer seed = 32'h4017300D;

	initial fb_ready = 1'b1;

	// Stalls only when asked, so config changes never meet a held fragment
	always @(posedge clk)
		fb_ready <= !slow || $random(seed) % 2 == 0;
endmodule

`default_nettype wire

/* verification/pfp_pipe_sva.sv */
// Port assertions for the pixel fragment pipeline
`timescale 1ns/1ns
`default_nettype none

module pfp_pipe_sva (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Register port
	input wire logic        reg_re,
	input wire logic [31:0] reg_rdata,
	// Fragment in
	input wire logic        frag_valid,
	input wire logic        frag_ready,
	input wire logic        frag_lfb,
	input wire logic [12:0] frag_x,
	input wire logic [12:0] frag_y,
	// Frame-buffer write
	input wire logic        fb_valid,
	input wire logic        fb_ready,
	input wire logic [12:0] fb_x,
	input wire logic [12:0] fb_y,
	input wire logic [15:0] fb_rgb,
	input wire logic [15:0] fb_aux,
	input wire logic        fb_aux_we
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_take;
		frag_valid && frag_ready;
	endsequence
	sequence s_flow;
		frag_ready [*2];
	endsequence

	a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !fb_valid && frag_ready && reg_rdata == 32'h0)
		else $error("outputs not idle after reset");
	a_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	a_ready_comb: assert property (frag_ready == (!fb_valid || fb_ready))
		else $error("ready does not follow the write stall");
	a_hold_pos: assert property (fb_valid && !fb_ready |=> fb_valid && $stable(fb_x) && $stable(fb_y))
		else $error("stalled write lost or moved");
	a_hold_data: assert property (fb_valid && !fb_ready |=> $stable({fb_rgb, fb_aux, fb_aux_we}))
		else $error("stalled write data changed");
	a_rise_cause: assert property ($rose(fb_valid) && $past(frag_ready, 3) |-> $past(frag_valid && frag_ready, 3))
		else $error("write without a fragment three cycles back");
	a_coord_pass: assert property (s_take ##1 s_flow |=> !fb_valid
		|| (fb_x == $past(frag_x, 3) && fb_y == $past(frag_y, 3)))
		else $error("coordinates altered in the pipe");
	a_lfb_noaux: assert property (s_take ##0 frag_lfb ##1 s_flow |=> fb_valid && !fb_aux_we)
		else $error("host pixel dropped or wrote aux");
endmodule

bind pfp_pipe pfp_pipe_sva i_pfp_pipe_sva (.clk(clk), .rst_n(rst_n), .reg_re(reg_re), .reg_rdata(reg_rdata),
	.frag_valid(frag_valid), .frag_ready(frag_ready), .frag_lfb(frag_lfb), .frag_x(frag_x), .frag_y(frag_y),
	.fb_valid(fb_valid), .fb_ready(fb_ready), .fb_x(fb_x), .fb_y(fb_y), .fb_rgb(fb_rgb), .fb_aux(fb_aux),
	.fb_aux_we(fb_aux_we));

`default_nettype wire

/* verification/pfp_pipe_tb.sv */
// Self-checking bench for the pixel fragment pipeline
`timescale 1ns/1ns
`default_nettype none
`include "pfp_map.vh"

module pfp_pipe_tb;
	logic        clk, rst_n, reg_we, reg_re, pal_ld_valid, frag_valid, frag_lfb, slow, ok, dith_on;
	logic [7:0]  reg_addr, pal_ld_idx, frag_tex, frag_cov, cv;
	logic [31:0] reg_wdata, reg_rdata, frag_argb, c;
	logic [23:0] pal_ld_rgb;
	logic [12:0] frag_x, frag_y, fb_x, fb_y;
	logic [1:0]  frag_tfmt;
	logic [15:0] frag_z, frag_w, frag_old_rgb, frag_old_aux, fb_rgb, fb_aux, z, zb, o, orgb;
	logic        frag_ready, fb_valid, fb_ready, fb_aux_we;
	logic [58:0] exp_q[$];
	integer      fails = 0, compares = 0, seed = 32'h4017300D, rejs = 0, passes = 0, cyc = 0, i, f, aa;

	pfp_pipe i_pfp_pipe (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata), .pal_ld_valid(pal_ld_valid), .pal_ld_idx(pal_ld_idx),
		.pal_ld_rgb(pal_ld_rgb), .frag_valid(frag_valid), .frag_ready(frag_ready), .frag_lfb(frag_lfb),
		.frag_x(frag_x), .frag_y(frag_y), .frag_argb(frag_argb), .frag_tex(frag_tex), .frag_tfmt(frag_tfmt),
		.frag_cov(frag_cov), .frag_z(frag_z), .frag_w(frag_w), .frag_old_rgb(frag_old_rgb),
		.frag_old_aux(frag_old_aux), .fb_valid(fb_valid), .fb_ready(fb_ready), .fb_x(fb_x), .fb_y(fb_y),
		.fb_rgb(fb_rgb), .fb_aux(fb_aux), .fb_aux_we(fb_aux_we));
	pfp_fb_mem i_pfp_fb_mem (.clk(clk), .slow(slow), .fb_ready(fb_ready));

	task automatic give_verdict;
		$display("Counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input string nm, input logic [58:0] seen, input logic [58:0] want);
		compares++;
		if (seen !== want)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, want, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{reg_we, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk);
		reg_we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		@(posedge clk);
		{reg_re, reg_addr} <= {1'b1, a};
		@(posedge clk);
		reg_re <= 1'b0;
		#1;
		check("reg_rdata", 59'(reg_rdata), 59'(want));
	endtask

	// Valid stays up, so calls in a row go back to back
	task automatic send(input logic lfb, input logic [1:0] tf, input logic [7:0] tx, input logic [31:0] cl,
		input logic [15:0] zi, input logic [15:0] oa, input logic pass, input logic [15:0] rgb, input logic [15:0] za);
		logic [12:0] x, y;
		x = 13'($random(seed));
		y = 13'($random(seed));
		if (pass)
			exp_q.push_back({x, y, dith_on ? dith(cl[23:0], x[1:0], y[1:0]) : rgb, lfb ? 16'h0 : za, !lfb});
		{frag_valid, frag_lfb, frag_x, frag_y, frag_argb, frag_tex, frag_tfmt, frag_z, frag_old_aux} <=
			{1'b1, lfb, x, y, cl, tx, tf, zi, oa};
		{frag_w, frag_old_rgb} <= {16'($random(seed)), orgb};
		@(posedge clk);
		while (!frag_ready)
			@(posedge clk);
	endtask

	task automatic idle;
		frag_valid <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	function automatic logic [15:0] tr(input logic [23:0] v);
		return {v[23:19], v[15:10], v[7:3]};
	endfunction

	function automatic logic [15:0] sat(input logic [15:0] a, input logic [15:0] b);
		return (32'(a) + 32'(b) > 32'hFFFF) ? 16'hFFFF : a + b;
	endfunction

	// Mean of pixel and fog colour, the weight being one half
	function automatic logic [23:0] half(input logic [23:0] a, input logic [23:0] b);
		logic [8:0] r, g, bl;
		r = a[23:16] + b[23:16];
		g = a[15:8] + b[15:8];
		bl = a[7:0] + b[7:0];
		return {r[8:1], g[8:1], bl[8:1]};
	endfunction

	// Source over a white destination, weights in 1.8 form
	function automatic logic [23:0] blend(input logic [23:0] s, input integer a);
		integer      k, v;
		logic [23:0] r;
		for (k = 0; k < 3; k++)
		begin
			v = (s[k*8 +: 8] * a + 255 * (256 - a)) / 256;
			r[k*8 +: 8] = 8'(v);
		end
		return r;
	endfunction

	function automatic logic [23:0] expand(input logic [7:0] t);
		integer y, r, b;
		y = t[7:4] * 17;
		r = y + $signed(t[3:2]) * 64;
		b = y + $signed(t[1:0]) * 64;
		r = (r < 0) ? 0 : (r > 255) ? 255 : r;
		b = (b < 0) ? 0 : (b > 255) ? 255 : b;
		return {8'(r), 8'(y), 8'(b)};
	endfunction

	// Ordered 4x4 threshold, saturating at full scale
	function automatic logic [15:0] dith(input logic [23:0] v, input logic [1:0] x, input logic [1:0] y);
		logic [63:0] m;
		logic [3:0]  t;
		logic [8:0]  r, g, b;
		m = 64'h5D7F91B36E4CA280;
		t = m[{y, x, 2'b00} +: 4];
		r = v[23:16] + t[3:1];
		g = v[15:8] + t[3:2];
		b = v[7:0] + t[3:1];
		return {r[8] ? 5'h1F : r[7:3], g[8] ? 6'h3F : g[7:2], b[8] ? 5'h1F : b[7:3]};
	endfunction

	function automatic logic dpass(input integer fn, input logic [15:0] n, input logic [15:0] s);
		return (fn == 1 && n < s) || (fn == 2 && n == s) || (fn == 3 && n <= s) || (fn == 4 && n > s)
			|| (fn == 5 && n != s) || (fn == 6 && n >= s) || fn == 7;
	endfunction

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (rst_n && fb_valid && fb_ready)
		begin
			passes++;
			if (exp_q.size() == 0)
				check("fb extra", 59'(1), 59'(0));
			else
				check("fb beat", {fb_x, fb_y, fb_rgb, fb_aux_we ? fb_aux : 16'h0, fb_aux_we}, exp_q.pop_front());
		end
		if (cyc == 20000)
		begin
			fails++;
			give_verdict();
		end
	end

	initial
	begin
		{rst_n, slow, reg_we, reg_re, reg_addr, reg_wdata, pal_ld_valid, pal_ld_idx, pal_ld_rgb} = '0;
		{frag_valid, frag_lfb, frag_x, frag_y, frag_argb, frag_tex, frag_tfmt, frag_z, frag_w} = '0;
		{frag_old_rgb, frag_old_aux} = '0;
		frag_cov = 8'hFF;
		dith_on = 1'b0;
		orgb = 16'($random(seed));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(`PFP_OFF_DEPTH, 32'h0000001C);
		rd(`PFP_OFF_COMB, 32'h00000102);
		rd(`PFP_OFF_PALDAT, 32'h0);
		wr(8'h30, 32'hFFFFFFFF);
		rd(8'h30, 32'h0);
		$display("Test register reset done");
		wr(`PFP_OFF_COMB, 32'h002);
		wr(`PFP_OFF_BIAS, 32'h0);
		slow <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			c = $random(seed);
			send(1, 0, 0, c, 0, 0, 1, tr(c[23:0]), 0);
		end
		idle();
		slow <= 1'b0;
		$display("Test host pixels done");
		for (f = 0; f < 8; f++)
		begin
			wr(`PFP_OFF_DEPTH, 32'(1 + f * 4));
			wr(`PFP_OFF_BIAS, f % 2 ? 32'h40 : 32'h0);
			for (i = 0; i < 4; i++)
			begin
				c = $random(seed);
				z = (i == 3) ? 16'hFFF0 : 16'($random(seed));
				zb = sat(z, f % 2 ? 16'h40 : 16'h0);
				o = (i == 0) ? zb : (i == 1) ? zb + 16'h1 : 16'($random(seed));
				ok = dpass(f, zb, o);
				rejs += !ok;
				send(0, 0, 0, c, z, o, ok, tr(c[23:0]), zb);
			end
			idle();
		end
		$display("Test depth functions done");
		wr(`PFP_OFF_BIAS, 32'h0);
		wr(`PFP_OFF_CKLO, 32'h00123456);
		wr(`PFP_OFF_CKHI, 32'h00345678);
		for (f = 0; f < 2; f++)
		begin
			wr(`PFP_OFF_DEPTH, f ? 32'h9D : 32'h5D);
			for (i = 0; i < 3; i++)
			begin
				c = (i == 0) ? 32'h00123456 : (i == 1) ? 32'h00123457 : 32'h00400000;
				send(0, 0, 0, c, 16'h100, 0, f ? i != 2 : i != 0, tr(c[23:0]), 16'h100);
			end
			idle();
		end
		$display("Test chroma done");
		wr(`PFP_OFF_DEPTH, 32'h1D);
		wr(`PFP_OFF_PALOFS, 32'h05);
		wr(`PFP_OFF_PALDAT, 32'h03A1B2C3);
		pal_ld_valid <= 1'b1;
		{pal_ld_idx, pal_ld_rgb} <= 32'h04D4E5F6;
		@(posedge clk);
		pal_ld_valid <= 1'b0;
		wr(`PFP_OFF_PALOFS, 32'h0);
		send(0, 1, 8'h08, 0, 0, 0, 1, tr(24'hA1B2C3), 0);
		send(0, 1, 8'h09, 0, 0, 0, 1, tr(24'hD4E5F6), 0);
		idle();
		wr(`PFP_OFF_PALOFS, 32'h04);
		send(0, 1, 8'h05, 0, 0, 0, 1, tr(24'hD4E5F6), 0);
		idle();
		$display("Test palette done");
		for (i = 0; i < 64; i++)
			wr(`PFP_OFF_FOGTAB, 32'(i * 256 + 128));
		wr(`PFP_OFF_FOGCOL, 32'h00204060);
		wr(`PFP_OFF_COMB, 32'h082);
		for (i = 0; i < 4; i++)
		begin
			c = $random(seed);
			send(0, 0, 0, c, 0, 0, 1, tr(half(c[23:0], 24'h204060)), 0);
		end
		idle();
		$display("Test fog done");
		orgb = 16'hFFFF;
		for (f = 0; f < 2; f++)
		begin
			wr(`PFP_OFF_COMB, f ? 32'h002 : 32'h059);
			wr(`PFP_OFF_DEPTH, f ? 32'h11D : 32'h1D);
			for (i = 0; i < 4; i++)
			begin
				c = $random(seed);
				cv = f ? 8'($random(seed)) & 8'hFE : 8'hFF;
				aa = f ? (c[31:24] * cv) >> 8 : c[31:24];
				frag_cov <= cv;
				send(0, 0, 0, c, 0, 0, 1, tr(blend(c[23:0], aa)), 0);
			end
			idle();
		end
		frag_cov <= 8'hFF;
		$display("Test blend and edge done");
		wr(`PFP_OFF_DEPTH, 32'h1D);
		for (i = 0; i < 4; i++)
		begin
			c = $random(seed);
			send(0, 2, c[7:0], 0, 0, 0, 1, tr(expand(c[7:0])), 0);
		end
		idle();
		$display("Test compressed texels done");
		wr(`PFP_OFF_COMB, 32'h102);
		dith_on = 1'b1;
		for (i = 0; i < 8; i++)
		begin
			c = $random(seed);
			send(1, 0, 0, c, 0, 0, 1, 0, 0);
		end
		idle();
		$display("Test dither done");
		check("exp left", 59'(exp_q.size()), 59'(0));
		rd(`PFP_OFF_STAT, {16'(rejs), 16'(passes)});
		give_verdict();
	end
endmodule

`default_nettype wire
